// *** include/dsb_pkg.sv ***
// Overview of operation
// - Enable with torque-cut open raises fault
// - Hardware disable switches power stage off immediately
// - Stops accepted from input and fieldbus
// - Disable mode 0 cuts power at once
// - Disable mode 2 decelerates, then cuts power
// - Brake on low speed or timeout
// - Stop input: controlled stop, disable, brake
// - Immediate brake option after hardware disable/fault
// - Immediate-disable fault cuts power at once
// - Dynamic-braking fault cuts control, brakes dynamically
// - Controlled-stop fault decelerates then cuts power
// - Stop request beats any enable request
// - Category 0 beats category 1, any mode
// - Category 1 keeps power until shutdown done
// - Stop function state reported to control
// - Losing axis active engages holding brake after low speed, timeout or immediate brake
// - Torque-cut opening removes torque, raises fault while axis active
package dsb_pkg;
	// ========================================
	// Widths and codes
	localparam int DSB_SPD_W = 16;
	localparam int DSB_TMO_W = 24;
	localparam logic [1:0] DSB_DIS_IMM = 2'h0;
	localparam logic [1:0] DSB_DIS_CTRL = 2'h2;
	localparam logic [1:0] DSB_CAT_NONE = 2'h3;
	localparam logic [1:0] DSB_CAT0 = 2'h0;
	localparam logic [1:0] DSB_CAT1 = 2'h1;
	localparam logic [1:0] DSB_CAT2 = 2'h2;

	// ========================================
	// Sequencer states
	typedef enum logic [4:0] {
		DSB_OFF = 5'h01,
		DSB_RUN = 5'h02,
		DSB_DECEL = 5'h04,
		DSB_COAST = 5'h08,
		DSB_HOLD = 5'h10
	} dsb_state_t;

	// ========================================
	// Stop requests and fault classes
	typedef struct packed {
		logic hw_off;
		logic sto_off;
		logic fault_imm;
		logic fault_dyn;
		logic fault_ctrl;
		logic sw_dis;
		logic din_stop;
		logic bus_stop;
	} dsb_req_t;

	// Configuration
	typedef struct packed {
		logic [1:0] disable_mode_select;
		logic immediate_brake_select;
		logic [DSB_SPD_W-1:0] brake_speed_threshold;
		logic [DSB_TMO_W-1:0] brake_timeout;
	} dsb_cfg_t;

	// Status to control logic
	typedef struct packed {
		logic axis_active;
		logic power_stage_en;
		logic dyn_brake_en;
		logic decel_cmd;
		logic brake_apply;
		logic safe_torque_off_fault;
		logic [1:0] stop_category;
	} dsb_stat_t;
endpackage

// *** hdl/dsb_brake_timer.sv ***
`timescale 1ns/1ns
// ========================================
// Brake-apply decision: speed threshold or timeout
module dsb_brake_timer
	import dsb_pkg::*;
#(
	parameter int TMO_W = DSB_TMO_W
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic start_i,
	input wire logic run_i,
	input wire logic [DSB_SPD_W-1:0] speed_i,
	input wire logic [DSB_SPD_W-1:0] thresh_i,
	input wire logic [TMO_W-1:0] timeout_i,
	// Result
	output logic due_o
);
	typedef struct packed {
		logic [TMO_W-1:0] cnt;
		logic due;
	} dsb_tmr_t;

	dsb_tmr_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		if (start_i) begin
			// Counter starts with the stop procedure
			s_d.cnt = '0;
			s_d.due = 1'b0;
		end else if (run_i && !s_q.due) begin
			if (speed_i < thresh_i || s_q.cnt >= timeout_i) begin
				s_d.due = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + 1'b1;
			end
		end else if (!run_i) begin
			s_d.due = 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign due_o = s_q.due;

	// ========================================
	// Checks
	property p_tmo_due;
		@(posedge mclk_i) disable iff (!rst_n_i) (run_i && !start_i && !s_q.due && s_q.cnt >= timeout_i)
			|=> due_o;
	endproperty
	a_tmo_due: assert property (p_tmo_due) else $error("timeout did not set brake due");

	property p_start_clr;
		@(posedge mclk_i) disable iff (!rst_n_i) start_i |=> !due_o && s_q.cnt == '0;
	endproperty
	a_start_clr: assert property (p_start_clr) else $error("timer not restarted");

	property p_idle_clr;
		@(posedge mclk_i) disable iff (!rst_n_i) (!run_i && !start_i) |=> !due_o;
	endproperty
	a_idle_clr: assert property (p_idle_clr) else $error("brake due outside stop");
endmodule

// *** hdl/dsb_seq.sv ***
`timescale 1ns/1ns
// ========================================
// Drive stop and brake sequencer
module dsb_seq
	import dsb_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Enables and stop requests
	input wire logic hw_enable_i,
	input wire logic torque_cut_input_i,
	input wire logic software_enable_i,
	input wire logic software_disable_cmd_i,
	input wire logic din_stop_i,
	input wire logic bus_stop_i,
	// Fault classes
	input wire logic fault_imm_i,
	input wire logic fault_dyn_i,
	input wire logic fault_ctrl_i,
	input wire logic fault_clear_i,
	// Configuration and feedback
	input wire dsb_cfg_t cfg_i,
	input wire logic [DSB_SPD_W-1:0] motor_speed_i,
	input wire logic decel_done_i,
	// Status and power-stage controls
	output dsb_stat_t stat_o
);
	typedef struct packed {
		dsb_state_t st;
		logic [1:0] cat;
		logic hw_q;
		logic sto_fault;
		dsb_stat_t out;
	} dsb_seq_t;

	dsb_seq_t s_q, s_d;
	dsb_req_t req;
	logic any_stop, cat0, cat1, cat2, imm_brake, tmr_start, tmr_run, brake_due;

	// ========================================
	// Request decode and priority
	always_comb begin
		req.hw_off = !hw_enable_i;
		req.sto_off = !torque_cut_input_i;
		req.fault_imm = fault_imm_i;
		req.fault_dyn = fault_dyn_i;
		req.fault_ctrl = fault_ctrl_i;
		req.sw_dis = software_disable_cmd_i || !software_enable_i;
		req.din_stop = din_stop_i;
		req.bus_stop = bus_stop_i;
		cat0 = req.hw_off || req.sto_off || req.fault_imm || req.fault_dyn
			|| (req.sw_dis && cfg_i.disable_mode_select != DSB_DIS_CTRL);
		cat1 = req.fault_ctrl || (req.sw_dis && cfg_i.disable_mode_select == DSB_DIS_CTRL);
		cat2 = req.din_stop || req.bus_stop;
		any_stop = cat0 || cat1 || cat2 || s_q.sto_fault;
		imm_brake = cfg_i.immediate_brake_select
			&& (req.hw_off || req.sto_off || req.fault_imm || req.fault_dyn);
	end

	// ========================================
	// Sequencer
	always_comb begin
		s_d = s_q;
		tmr_start = 1'b0;
		s_d.hw_q = hw_enable_i;
		// Enable rising while torque-cut open
		if (hw_enable_i && !s_q.hw_q && !torque_cut_input_i) begin
			s_d.sto_fault = 1'b1;
		end else if (s_q.out.axis_active && !torque_cut_input_i) begin
			s_d.sto_fault = 1'b1;
		end else if (fault_clear_i && torque_cut_input_i) begin
			s_d.sto_fault = 1'b0;
		end
		unique case (s_q.st)
			DSB_OFF: begin
				// Any stop request blocks enabling
				if (!any_stop && software_enable_i && hw_enable_i) begin
					s_d.st = DSB_RUN;
					s_d.cat = DSB_CAT_NONE;
				end
			end
			DSB_RUN: begin
				if (cat0) begin
					s_d.st = DSB_COAST;
					s_d.cat = DSB_CAT0;
					tmr_start = 1'b1;
				end else if (cat1 || cat2) begin
					s_d.st = DSB_DECEL;
					s_d.cat = cat1 ? DSB_CAT1 : DSB_CAT2;
					tmr_start = 1'b1;
				end
			end
			DSB_DECEL: begin
				if (cat0) begin
					s_d.st = DSB_COAST;
					s_d.cat = DSB_CAT0;
				end else if (decel_done_i) begin
					s_d.st = DSB_COAST;
				end
			end
			DSB_COAST: begin
				if (brake_due || imm_brake) begin
					s_d.st = DSB_HOLD;
				end
			end
			DSB_HOLD: begin
				if (!any_stop) begin
					s_d.st = DSB_OFF;
				end
			end
			default: begin
				s_d.st = DSB_OFF;
			end
		endcase
		// Outputs
		s_d.out.axis_active = (s_d.st == DSB_RUN) || (s_d.st == DSB_DECEL);
		s_d.out.power_stage_en = s_d.out.axis_active;
		s_d.out.decel_cmd = (s_d.st == DSB_DECEL);
		s_d.out.dyn_brake_en = (s_d.st == DSB_COAST) && req.fault_dyn;
		s_d.out.brake_apply = !s_d.out.axis_active && !(s_d.st == DSB_COAST);
		s_d.out.safe_torque_off_fault = s_d.sto_fault;
		s_d.out.stop_category = s_d.cat;
	end

	assign tmr_run = (s_q.st == DSB_DECEL) || (s_q.st == DSB_COAST);

	dsb_brake_timer #(
		.TMO_W(DSB_TMO_W)
	) u_tmr (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.start_i(tmr_start),
		.run_i(tmr_run),
		.speed_i(motor_speed_i),
		.thresh_i(cfg_i.brake_speed_threshold),
		.timeout_i(cfg_i.brake_timeout),
		.due_o(brake_due)
	);

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q.st <= DSB_OFF;
			s_q.cat <= DSB_CAT_NONE;
			s_q.hw_q <= 1'b0;
			s_q.sto_fault <= 1'b0;
			s_q.out <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, DSB_CAT_NONE};
		end else begin
			s_q <= s_d;
		end
	end

	assign stat_o = s_q.out;

	// ========================================
	// Checks
	property p_hw_off;
		@(posedge mclk_i) disable iff (!rst_n_i) !hw_enable_i |=> !stat_o.power_stage_en;
	endproperty
	a_hw_off: assert property (p_hw_off) else $error("power on after hw disable");

	property p_sto_fault;
		@(posedge mclk_i) disable iff (!rst_n_i) (hw_enable_i && !$past(hw_enable_i) && !torque_cut_input_i)
			|=> stat_o.safe_torque_off_fault;
	endproperty
	a_sto_fault: assert property (p_sto_fault) else $error("missing torque-cut fault");

	property p_brake_active;
		@(posedge mclk_i) disable iff (!rst_n_i) stat_o.axis_active |-> !stat_o.brake_apply;
	endproperty
	a_brake_active: assert property (p_brake_active) else $error("brake while active");

	property p_drop_brake;
		@(posedge mclk_i) disable iff (!rst_n_i) $fell(stat_o.axis_active) && cfg_i.immediate_brake_select
			&& !hw_enable_i |=> ##[0:2] stat_o.brake_apply;
	endproperty
	a_drop_brake: assert property (p_drop_brake) else $error("no immediate brake");

	property p_cat0_wins;
		@(posedge mclk_i) disable iff (!rst_n_i) (s_q.st == DSB_RUN && cat0 && cat1) |=> stat_o.stop_category == DSB_CAT0;
	endproperty
	a_cat0_wins: assert property (p_cat0_wins) else $error("cat0 lost priority");

	property p_cat1_power;
		@(posedge mclk_i) disable iff (!rst_n_i) stat_o.decel_cmd |-> stat_o.power_stage_en;
	endproperty
	a_cat1_power: assert property (p_cat1_power) else $error("power lost in decel");

	property p_stop_blocks;
		@(posedge mclk_i) disable iff (!rst_n_i) (s_q.st == DSB_OFF && any_stop) |=> !stat_o.axis_active;
	endproperty
	a_stop_blocks: assert property (p_stop_blocks) else $error("enable beat stop");

	property p_mode2;
		@(posedge mclk_i) disable iff (!rst_n_i) (s_q.st == DSB_RUN && software_disable_cmd_i && !cat0
			&& cfg_i.disable_mode_select == DSB_DIS_CTRL) |=> stat_o.decel_cmd ##0 stat_o.stop_category == DSB_CAT1;
	endproperty
	a_mode2: assert property (p_mode2) else $error("mode 2 did not decelerate");

	property p_speed_brake;
		@(posedge mclk_i) disable iff (!rst_n_i) (s_q.st == DSB_COAST && brake_due) |=> stat_o.brake_apply;
	endproperty
	a_speed_brake: assert property (p_speed_brake) else $error("brake not applied");

	// ========================================
	// Stop class and status checks
	property p_sto_torque;
		@(posedge mclk_i) disable iff (!rst_n_i) !torque_cut_input_i |=> !stat_o.power_stage_en;
	endproperty
	a_sto_torque: assert property (p_sto_torque) else $error("power on with torque cut open");

	property p_sto_run;
		@(posedge mclk_i) disable iff (!rst_n_i) (stat_o.axis_active && !torque_cut_input_i)
			|=> stat_o.safe_torque_off_fault;
	endproperty
	a_sto_run: assert property (p_sto_run) else $error("no fault on torque cut in operation");

	property p_sto_hold;
		@(posedge mclk_i) disable iff (!rst_n_i) (stat_o.safe_torque_off_fault && !torque_cut_input_i)
			|=> stat_o.safe_torque_off_fault;
	endproperty
	a_sto_hold: assert property (p_sto_hold) else $error("torque-cut fault lost while open");

	property p_imm_fault;
		@(posedge mclk_i) disable iff (!rst_n_i) fault_imm_i |=> !stat_o.power_stage_en;
	endproperty
	a_imm_fault: assert property (p_imm_fault) else $error("power on after immediate fault");

	property p_dyn_fault;
		@(posedge mclk_i) disable iff (!rst_n_i) (fault_dyn_i && stat_o.axis_active)
			|=> stat_o.dyn_brake_en && !stat_o.power_stage_en;
	endproperty
	a_dyn_fault: assert property (p_dyn_fault) else $error("no dynamic braking on fault");

	property p_dyn_only;
		@(posedge mclk_i) disable iff (!rst_n_i) stat_o.dyn_brake_en |-> !stat_o.power_stage_en;
	endproperty
	a_dyn_only: assert property (p_dyn_only) else $error("dynamic braking with power on");

	property p_ctrl_fault;
		@(posedge mclk_i) disable iff (!rst_n_i) (s_q.st == DSB_RUN && fault_ctrl_i && !cat0)
			|=> stat_o.decel_cmd && stat_o.power_stage_en;
	endproperty
	a_ctrl_fault: assert property (p_ctrl_fault) else $error("controlled fault did not decelerate");

	property p_mode0;
		@(posedge mclk_i) disable iff (!rst_n_i) (software_disable_cmd_i && cfg_i.disable_mode_select == DSB_DIS_IMM)
			|=> !stat_o.power_stage_en;
	endproperty
	a_mode0: assert property (p_mode0) else $error("mode 0 kept power on");

	property p_din_stop;
		@(posedge mclk_i) disable iff (!rst_n_i) (s_q.st == DSB_RUN && din_stop_i && !cat0 && !cat1)
			|=> stat_o.decel_cmd && stat_o.stop_category == DSB_CAT2;
	endproperty
	a_din_stop: assert property (p_din_stop) else $error("input stop did not decelerate");

	property p_bus_stop;
		@(posedge mclk_i) disable iff (!rst_n_i) (s_q.st == DSB_RUN && bus_stop_i && !cat0)
			|=> stat_o.decel_cmd && stat_o.power_stage_en;
	endproperty
	a_bus_stop: assert property (p_bus_stop) else $error("fieldbus stop ignored");

	property p_decel_keep;
		@(posedge mclk_i) disable iff (!rst_n_i) (s_q.st == DSB_DECEL && !decel_done_i && !cat0)
			|=> stat_o.power_stage_en;
	endproperty
	a_decel_keep: assert property (p_decel_keep) else $error("power dropped before decel done");

	property p_decel_end;
		@(posedge mclk_i) disable iff (!rst_n_i) (s_q.st == DSB_DECEL && decel_done_i && !cat0)
			|=> !stat_o.power_stage_en && !stat_o.decel_cmd;
	endproperty
	a_decel_end: assert property (p_decel_end) else $error("power kept after decel done");

	property p_cat0_decel;
		@(posedge mclk_i) disable iff (!rst_n_i) (s_q.st == DSB_DECEL && cat0)
			|=> stat_o.stop_category == DSB_CAT0 && !stat_o.power_stage_en;
	endproperty
	a_cat0_decel: assert property (p_cat0_decel) else $error("cat0 lost priority in decel");

	property p_slow_due;
		@(posedge mclk_i) disable iff (!rst_n_i) (tmr_run && !brake_due && motor_speed_i < cfg_i.brake_speed_threshold)
			|=> brake_due;
	endproperty
	a_slow_due: assert property (p_slow_due) else $error("low speed did not set brake due");

	property p_imm_brake;
		@(posedge mclk_i) disable iff (!rst_n_i) (s_q.st == DSB_COAST && imm_brake) |=> stat_o.brake_apply;
	endproperty
	a_imm_brake: assert property (p_imm_brake) else $error("immediate brake not applied");

	property p_idle_brake;
		@(posedge mclk_i) disable iff (!rst_n_i) (s_q.st == DSB_OFF || s_q.st == DSB_HOLD) |-> stat_o.brake_apply;
	endproperty
	a_idle_brake: assert property (p_idle_brake) else $error("brake released while inactive");

	property p_hold_stays;
		@(posedge mclk_i) disable iff (!rst_n_i) (s_q.st == DSB_HOLD && any_stop) |=> !stat_o.axis_active;
	endproperty
	a_hold_stays: assert property (p_hold_stays) else $error("restart with stop pending");

	property p_run_start;
		@(posedge mclk_i) disable iff (!rst_n_i) (s_q.st == DSB_OFF && !any_stop && software_enable_i && hw_enable_i)
			|=> stat_o.axis_active && stat_o.stop_category == DSB_CAT_NONE;
	endproperty
	a_run_start: assert property (p_run_start) else $error("enable not reported");

	property p_run_cat;
		@(posedge mclk_i) disable iff (!rst_n_i) (stat_o.axis_active && !stat_o.decel_cmd) |-> stat_o.stop_category == DSB_CAT_NONE;
	endproperty
	a_run_cat: assert property (p_run_cat) else $error("stop category shown while running");
endmodule

// *** sim/dsb_motor_model.sv ***
`timescale 1ns/1ns
// ========================================
// Motor and brake model: speed follows the power stage
module dsb_motor_model
	import dsb_pkg::*;
(
	// Clock and test controls
	input wire logic mclk_i,
	input wire logic hold_i,
	input wire logic [DSB_SPD_W-1:0] run_spd_i,
	// Drive side
	input wire dsb_stat_t stat_i,
	output logic [DSB_SPD_W-1:0] speed_o,
	output logic decel_done_o
);
	// Hold keeps the shaft spinning so only the timeout or immediate brake can brake
	always @(posedge mclk_i) begin
		if (stat_i.power_stage_en && !stat_i.decel_cmd)
			speed_o <= run_spd_i;
		else if (!hold_i && speed_o > 16'h0040)
			speed_o <= speed_o - 16'h0040;
		else if (!hold_i)
			speed_o <= '0;
	end
	assign decel_done_o = stat_i.decel_cmd && speed_o == '0;
endmodule

// *** sim/drive_stop_brake_sequencer_bench.sv ***
`timescale 1ns/1ns
module drive_stop_brake_sequencer_bench;
	import dsb_pkg::*;
	logic mclk_i = 0, rst_n_i = 0, hw_en = 0, torque_cut_input = 1, sw_en = 0, sw_dis = 0, din = 0, bus = 0;
	logic f_imm = 0, f_dyn = 0, f_ctrl = 0, f_clr = 0, hold = 0, dd;
	logic [15:0] spd, run_spd = 16'h0800, lfsr = 16'h77dc;
	logic [7:0] pat [10] = '{8'h40, 8'h04, 8'h84, 8'h02, 8'h81, 8'h20, 8'h10, 8'h88, 8'ha8, 8'h86};
	dsb_cfg_t cfg = '{2'h0, 1'b0, 16'h0020, 24'h0003e8};
	dsb_stat_t st;
	int error_cnt = 0, checked = 0, n;
	always #5 mclk_i = ~mclk_i;
	dsb_seq u_dsb_seq (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .hw_enable_i(hw_en), .torque_cut_input_i(torque_cut_input),
		.software_enable_i(sw_en), .software_disable_cmd_i(sw_dis), .din_stop_i(din), .bus_stop_i(bus),
		.fault_imm_i(f_imm), .fault_dyn_i(f_dyn), .fault_ctrl_i(f_ctrl), .fault_clear_i(f_clr),
		.cfg_i(cfg), .motor_speed_i(spd), .decel_done_i(dd), .stat_o(st));
	dsb_motor_model u_dsb_motor_model (.mclk_i(mclk_i), .hold_i(hold), .run_spd_i(run_spd), .stat_i(st),
		.speed_o(spd), .decel_done_o(dd));
	// ========================================
	// Checking and waiting
	task chk(input logic [15:0] got, exp, input string m);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task test_done;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task cyc(input int k);
		repeat (k) @(negedge mclk_i);
	endtask
	function logic cond(input int s);
		return s ? st.axis_active === 1'b1 : st.brake_apply === 1'b1;
	endfunction
	task wt(input int s, lim);
		n = 0;
		while (!cond(s) && n < lim) begin
			cyc(1);
			n++;
		end
		if (!cond(s)) begin
			error_cnt++;
			$display("[FAIL] %0t wait %0d timed out", $time, s);
			test_done;
		end
	endtask
	// ========================================
	// Reference model of the stop category
	function logic [1:0] exp_cat;
		if (!hw_en || !torque_cut_input || f_imm || f_dyn || (sw_dis && cfg.disable_mode_select != DSB_DIS_CTRL))
			return DSB_CAT0;
		if (f_ctrl || sw_dis)
			return DSB_CAT1;
		return DSB_CAT2;
	endfunction
	function logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task run_up;
		{sw_dis, din, bus, f_imm, f_dyn, f_ctrl} = '0;
		{hw_en, torque_cut_input, sw_en} = 3'h7;
		lfsr = nxt(lfsr);
		run_spd = {4'h0, lfsr[11:0]} | 16'h0100;
		wt(1, 40);
		chk({st.power_stage_en, st.brake_apply}, 2'b10, "running");
		cyc(4);
	endtask
	task stop(input logic [1:0] ec);
		cyc(1);
		chk(st.stop_category, ec, "category");
		chk(st.power_stage_en, ec != DSB_CAT0, "power in stop");
		chk(st.dyn_brake_en, f_dyn, "dynamic brake");
		chk(st.decel_cmd, ec != DSB_CAT0, "decel command");
		wt(0, 400);
		chk(n < 300, 1'b1, "brake on speed");
		chk(st.power_stage_en | st.axis_active, 1'b0, "drop at brake");
		$display("stop case done at %0t", $time);
	endtask
	// ========================================
	// Main sequence
	initial begin
		cyc(5);
		chk({st.brake_apply, st.stop_category, st.power_stage_en}, 4'he, "reset");
		cyc(1);
		rst_n_i = 1;
		foreach (pat[i]) begin
			cfg.disable_mode_select = pat[i][7] ? DSB_DIS_CTRL : DSB_DIS_IMM;
			run_up;
			{hw_en, f_imm, f_dyn, f_ctrl, sw_dis, din, bus} = pat[i][6:0] ^ 7'h40;
			stop(exp_cat());
		end
		run_up;
		din = 1;
		cyc(3);
		hw_en = 0;
		cyc(1);
		chk({st.stop_category, st.power_stage_en, st.decel_cmd}, 4'h0, "cat0 in decel");
		wt(0, 400);
		$display("cat0 in decel case done at %0t", $time);
		hold = 1;
		cfg.brake_timeout = 24'h000014;
		for (int b = 0; b < 2; b++) begin
			cfg.immediate_brake_select = b[0];
			run_up;
			hw_en = 0;
			wt(0, 60);
			chk(b ? n <= 3 : n >= 20 && n <= 23, 1'b1, "brake timing");
			$display("brake timing case %0d done at %0t", b, $time);
		end
		hold = 0;
		run_up;
		torque_cut_input = 0;
		cyc(3);
		chk({st.safe_torque_off_fault, st.power_stage_en}, 2'b10, "torque cut in run");
		wt(0, 400);
		{hw_en, torque_cut_input, f_clr} = 3'h3;
		cyc(2);
		{torque_cut_input, f_clr} = 2'h0;
		cyc(2);
		hw_en = 1;
		cyc(3);
		chk({st.safe_torque_off_fault, st.axis_active}, 2'b10, "enable with cut");
		{torque_cut_input, f_clr} = 2'h3;
		cyc(2);
		{f_clr, din} = 2'h1;
		cyc(10);
		chk({st.safe_torque_off_fault, st.axis_active}, 2'b00, "stop beats enable");
		din = 0;
		wt(1, 40);
		$display("torque cut case done at %0t", $time);
		test_done;
	end
endmodule
